// [verilog/scsog_pkg.sv]
// shared constants for the clock select / oscillator gate host controller
// assumes a byte-wide device register port and an AXI4-Lite software port
package scsog_pkg;
  // device register addresses on the byte port
  localparam logic [19:0] DEV_PIN_MODE = 20'hfffa0;
  localparam logic [19:0] DEV_RUN_CTRL = 20'hfffa1;
  localparam logic [19:0] DEV_STAB_CNT = 20'hfffa2;
  localparam logic [19:0] DEV_STAB_SEL = 20'hfffa3;
  localparam logic [19:0] DEV_CLK_SEL = 20'hfffa4;
  // clock_run_control bit positions
  localparam int RUN_HS_STOP = 7;
  localparam int RUN_SUB_STOP = 6;
  localparam int RUN_HIO_STOP = 0;
  // system_clock_select bit positions
  localparam int SEL_CPU_STAT = 7;
  localparam int SEL_CPU_SRC = 6;
  localparam int SEL_MAIN_STAT = 5;
  localparam int SEL_MAIN_CTRL = 4;
  // own AXI4-Lite register byte offsets
  localparam logic [7:0] REG_REQUEST = 8'h00;
  localparam logic [7:0] REG_PIN_MODE = 8'h04;
  localparam logic [7:0] REG_STAB_SEL = 8'h08;
  localparam logic [7:0] REG_COMMAND = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // request register fields and reset (matches device reset state)
  localparam int REQ_CPU_SRC = 0;
  localparam int REQ_MAIN_CTRL = 1;
  localparam int REQ_HS_STOP = 2;
  localparam int REQ_SUB_STOP = 3;
  localparam int REQ_HIO_STOP = 4;
  localparam logic [4:0] REQ_RESET = 5'h0c;
  localparam logic [7:0] PIN_MODE_RESET = 8'h00;
  localparam logic [2:0] STAB_SEL_RESET = 3'h7;
  // device register values after reset, as the host first assumes them
  localparam logic [7:0] RUN_CTRL_RESET = 8'hc0;
  localparam logic [7:0] SEL_CTRL_RESET = 8'h00;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_INIT = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_SKIPPED = 3;
  localparam int ST_CLK_SEL_LSB = 8;
  localparam int ST_RUN_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // clock rate and subsystem settle time
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SUB_SETTLE_US_DEF = 1000;

  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_WR_PIN = 5'h01, S_WR_STAB = 5'h03, S_RD_CSC = 5'h02,
    S_CAP_CSC = 5'h06, S_WR_START = 5'h07, S_RD_STABILIZATION_COUNTER_STATUS = 5'h05, S_CAP_STABILIZATION_COUNTER_STATUS = 5'h04,
    S_SUB_WAIT = 5'h0c, S_RD_CKC = 5'h0d, S_CAP_CKC = 5'h0f, S_WR_CSS0 = 5'h0e,
    S_RD_CLS = 5'h0a, S_CAP_CLS = 5'h0b, S_WR_MCM = 5'h09, S_RD_MCS = 5'h08,
    S_CAP_MCS = 5'h18, S_WR_CSS = 5'h19, S_RD_FIN = 5'h1b, S_CAP_FIN = 5'h1a,
    S_WR_STOP = 5'h1e
  } scsog_state_t;
endpackage

// [verilog/scsog_host.sv]
// host controller that programs the clock select and oscillator run registers
// assumes the device byte port returns read data one cycle after dev_rd
// What this block does
// - never change main control while sub selected
// - always write zeros to select bits 3-0
// - hold peripherals while switching cpu clock
// - write pin mode before run control
// - write stabilization select before starting crystal
// - poll stabilization counter after main crystal start
// - wait settle time after sub crystal start
// - never stop the clock feeding the cpu
// - stop high-speed only when not in use
// - stop subsystem only when status is main
// - stop on-chip only when not in use
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module scsog_host
  import scsog_pkg::*;
#(
  parameter int unsigned SUB_SETTLE_US = SUB_SETTLE_US_DEF,
  parameter int AXI_AW = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // axi4-lite write
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device register port
  output logic [19:0] dev_addr,
  output logic [7:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [7:0] dev_rdata,
  // peripheral quiesce request
  output logic periph_hold
);
  localparam int unsigned SUB_CYC = SUB_SETTLE_US * CLK_MHZ;

  // ---------------- software register port ----------------
  logic [AXI_AW-1:0] aw_addr, next_aw_addr;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid, go, next_go;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [4:0] req, next_req;
  logic [7:0] pin_mode, next_pin_mode;
  logic [2:0] stab_sel, next_stab_sel;
  logic [31:0] status_word;
  logic [7:0] csc_cur, ckc_cur;

  scsog_state_t state, next_state;
  logic init_done, refused, skipped;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    status_word = 32'h0;
    status_word[ST_BUSY] = (state != S_IDLE);
    status_word[ST_INIT] = init_done;
    status_word[ST_REFUSED] = refused;
    status_word[ST_SKIPPED] = skipped;
    status_word[ST_CLK_SEL_LSB +: 8] = ckc_cur;
    status_word[ST_RUN_LSB +: 8] = csc_cur;
  end

  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_got = aw_got;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_w_got = w_got;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_req = req;
    next_pin_mode = pin_mode;
    next_stab_sel = stab_sel;
    next_go = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_got = 1'b1;
    end
    if (aw_got && w_got) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case (aw_addr[7:0])
        REG_REQUEST: if (w_strb[0]) next_req = w_data[4:0];
        REG_PIN_MODE: if (w_strb[0]) next_pin_mode = w_data[7:0];
        REG_STAB_SEL: if (w_strb[0]) next_stab_sel = w_data[2:0];
        REG_COMMAND: next_go = w_strb[0] && w_data[0];
        REG_STATUS: ;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        REG_REQUEST: next_rdata = {27'h0, req};
        REG_PIN_MODE: next_rdata = {24'h0, pin_mode};
        REG_STAB_SEL: next_rdata = {29'h0, stab_sel};
        REG_COMMAND: next_rdata = 32'h0;
        REG_STATUS: next_rdata = status_word;
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      aw_addr <= '0;
      aw_got <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      w_got <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      req <= REQ_RESET;
      pin_mode <= PIN_MODE_RESET;
      stab_sel <= STAB_SEL_RESET;
      go <= 1'b0;
    end else begin
      aw_addr <= next_aw_addr;
      aw_got <= next_aw_got;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      w_got <= next_w_got;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      req <= next_req;
      pin_mode <= next_pin_mode;
      stab_sel <= next_stab_sel;
      go <= next_go;
    end
  end

  // ---------------- device sequencer ----------------
  logic rd_wait, next_rd_wait;
  logic [19:0] next_dev_addr;
  logic [7:0] next_dev_wdata, next_csc_cur, next_ckc_cur;
  logic next_dev_wr, next_dev_rd, next_init_done, next_refused, next_skipped;
  logic x1_start, next_x1_start, xt_start, next_xt_start, hio_start, next_periph_hold;
  logic [31:0] sub_cnt, next_sub_cnt;
  logic bad_req, cpu_clock_source_status, main_source_status;
  logic [7:0] stab_mask, start_val, stop_bits;

  // the request must not leave the selected cpu source stopped
  assign bad_req = (req[REQ_CPU_SRC] && req[REQ_SUB_STOP]) ||
    (!req[REQ_CPU_SRC] && !req[REQ_MAIN_CTRL] && req[REQ_HIO_STOP]) ||
    (!req[REQ_CPU_SRC] && req[REQ_MAIN_CTRL] && req[REQ_HS_STOP]);
  assign stab_mask = 8'hff << (3'h7 - stab_sel);
  assign hio_start = csc_cur[RUN_HIO_STOP] && !req[REQ_HIO_STOP];
  assign start_val = csc_cur & ~{x1_start, xt_start, 5'h0, hio_start};
  assign cpu_clock_source_status = ckc_cur[SEL_CPU_STAT];
  assign main_source_status = ckc_cur[SEL_MAIN_STAT];
  always_comb begin
    stop_bits = 8'h0;
    stop_bits[RUN_HS_STOP] = req[REQ_HS_STOP] && ((!cpu_clock_source_status && !main_source_status) || cpu_clock_source_status);
    stop_bits[RUN_SUB_STOP] = req[REQ_SUB_STOP] && !cpu_clock_source_status;
    stop_bits[RUN_HIO_STOP] = req[REQ_HIO_STOP] && ((!cpu_clock_source_status && main_source_status) || cpu_clock_source_status);
  end

  always_comb begin
    next_state = state;
    next_rd_wait = 1'b0;
    next_dev_wr = 1'b0;
    next_dev_rd = 1'b0;
    next_dev_addr = dev_addr;
    next_dev_wdata = dev_wdata;
    next_csc_cur = csc_cur;
    next_ckc_cur = ckc_cur;
    next_x1_start = x1_start;
    next_xt_start = xt_start;
    next_sub_cnt = sub_cnt;
    next_init_done = init_done;
    next_refused = refused;
    next_skipped = skipped;
    next_periph_hold = periph_hold;
    unique case (state)
      S_IDLE: if (go) begin
        next_refused = bad_req;
        next_skipped = 1'b0;
        if (!bad_req) next_state = init_done ? S_RD_CSC : S_WR_PIN;
      end
      S_WR_PIN: begin
        next_dev_wr = 1'b1;
        next_dev_addr = DEV_PIN_MODE;
        next_dev_wdata = pin_mode;
        next_state = S_WR_STAB;
      end
      S_WR_STAB: begin
        next_dev_wr = 1'b1;
        next_dev_addr = DEV_STAB_SEL;
        next_dev_wdata = {5'h0, stab_sel};
        next_init_done = 1'b1;
        next_state = S_RD_CSC;
      end
      S_RD_CSC, S_RD_STABILIZATION_COUNTER_STATUS, S_RD_CKC, S_RD_CLS, S_RD_MCS, S_RD_FIN: begin
        next_dev_rd = 1'b1;
        next_rd_wait = 1'b1;
        next_dev_addr = (state == S_RD_CSC) ? DEV_RUN_CTRL :
          (state == S_RD_STABILIZATION_COUNTER_STATUS) ? DEV_STAB_CNT : DEV_CLK_SEL;
        next_state = scsog_state_t'(state ^ 5'h04);
        if (state == S_RD_MCS) next_state = S_CAP_MCS;
        if (state == S_RD_FIN) next_state = S_CAP_FIN;
        if (state == S_RD_CLS) next_state = S_CAP_CLS;
        if (state == S_RD_CKC) next_state = S_CAP_CKC;
        if (state == S_RD_STABILIZATION_COUNTER_STATUS) next_state = S_CAP_STABILIZATION_COUNTER_STATUS;
        if (state == S_RD_CSC) next_state = S_CAP_CSC;
      end
      S_CAP_CSC: if (!rd_wait) begin
        next_csc_cur = dev_rdata;
        next_x1_start = dev_rdata[RUN_HS_STOP] && !req[REQ_HS_STOP];
        next_xt_start = dev_rdata[RUN_SUB_STOP] && !req[REQ_SUB_STOP];
        next_state = S_WR_START;
      end
      S_WR_START: begin
        next_sub_cnt = 32'h0;
        if (start_val != csc_cur) begin
          next_dev_wr = 1'b1;
          next_dev_addr = DEV_RUN_CTRL;
          next_dev_wdata = start_val;
          next_csc_cur = start_val;
        end
        next_state = x1_start ? S_RD_STABILIZATION_COUNTER_STATUS : (xt_start ? S_SUB_WAIT : S_RD_CKC);
      end
      S_CAP_STABILIZATION_COUNTER_STATUS: if (!rd_wait) begin
        if ((dev_rdata & stab_mask) == stab_mask) begin
          next_state = xt_start ? S_SUB_WAIT : S_RD_CKC;
        end else begin
          next_state = S_RD_STABILIZATION_COUNTER_STATUS;
        end
      end
      S_SUB_WAIT: begin
        next_sub_cnt = sub_cnt + 32'h1;
        if (sub_cnt >= SUB_CYC - 1) next_state = S_RD_CKC;
      end
      S_CAP_CKC: if (!rd_wait) begin
        next_ckc_cur = dev_rdata;
        next_periph_hold = 1'b1;
        if (dev_rdata[SEL_MAIN_CTRL] == req[REQ_MAIN_CTRL]) next_state = S_WR_CSS;
        else next_state = dev_rdata[SEL_CPU_SRC] ? S_WR_CSS0 : S_WR_MCM;
      end
      S_WR_CSS0: begin
        next_dev_wr = 1'b1;
        next_dev_addr = DEV_CLK_SEL;
        next_dev_wdata = {3'h0, ckc_cur[SEL_MAIN_CTRL], 4'h0};
        next_state = S_RD_CLS;
      end
      S_CAP_CLS: if (!rd_wait) begin
        next_state = dev_rdata[SEL_CPU_STAT] ? S_RD_CLS : S_WR_MCM;
      end
      S_WR_MCM: begin
        next_dev_wr = 1'b1;
        next_dev_addr = DEV_CLK_SEL;
        next_dev_wdata = {3'h0, req[REQ_MAIN_CTRL], 4'h0};
        next_state = S_RD_MCS;
      end
      S_CAP_MCS: if (!rd_wait) begin
        next_state = (dev_rdata[SEL_MAIN_STAT] == req[REQ_MAIN_CTRL]) ? S_WR_CSS : S_RD_MCS;
      end
      S_WR_CSS: begin
        next_dev_wr = 1'b1;
        next_dev_addr = DEV_CLK_SEL;
        next_dev_wdata = {1'b0, req[REQ_CPU_SRC], 1'b0, req[REQ_MAIN_CTRL], 4'h0};
        next_state = S_RD_FIN;
      end
      S_CAP_FIN: if (!rd_wait) begin
        next_ckc_cur = dev_rdata;
        if (dev_rdata[SEL_CPU_STAT] == req[REQ_CPU_SRC]) begin
          next_periph_hold = 1'b0;
          next_state = S_WR_STOP;
        end else begin
          next_state = S_RD_FIN;
        end
      end
      S_WR_STOP: begin
        next_skipped = (({req[REQ_HS_STOP], req[REQ_SUB_STOP], 5'h0, req[REQ_HIO_STOP]}
          & ~stop_bits) != 8'h0);
        if ((csc_cur | stop_bits) != csc_cur) begin
          next_dev_wr = 1'b1;
          next_dev_addr = DEV_RUN_CTRL;
          next_dev_wdata = csc_cur | stop_bits;
          next_csc_cur = csc_cur | stop_bits;
        end
        // starts are spent: later run writes must not re-arm the settle checks
        next_x1_start = 1'b0;
        next_xt_start = 1'b0;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= S_IDLE;
      rd_wait <= 1'b0;
      dev_wr <= 1'b0;
      dev_rd <= 1'b0;
      dev_addr <= 20'h0;
      dev_wdata <= 8'h0;
      csc_cur <= RUN_CTRL_RESET;
      ckc_cur <= SEL_CTRL_RESET;
      x1_start <= 1'b0;
      xt_start <= 1'b0;
      sub_cnt <= 32'h0;
      init_done <= 1'b0;
      refused <= 1'b0;
      skipped <= 1'b0;
      periph_hold <= 1'b0;
    end else begin
      state <= next_state;
      rd_wait <= next_rd_wait;
      dev_wr <= next_dev_wr;
      dev_rd <= next_dev_rd;
      dev_addr <= next_dev_addr;
      dev_wdata <= next_dev_wdata;
      csc_cur <= next_csc_cur;
      ckc_cur <= next_ckc_cur;
      x1_start <= next_x1_start;
      xt_start <= next_xt_start;
      sub_cnt <= next_sub_cnt;
      init_done <= next_init_done;
      refused <= next_refused;
      skipped <= next_skipped;
      periph_hold <= next_periph_hold;
    end
  end

  // ---------------- checks on the device port ----------------
  logic sh_css, sh_mcm, pin_seen, stab_seen, x1_pend, xt_pend;
  logic [31:0] xt_age;
  logic wr_ckc, wr_csc, in_use_bit;
  assign wr_ckc = dev_wr && (dev_addr == DEV_CLK_SEL);
  assign wr_csc = dev_wr && (dev_addr == DEV_RUN_CTRL);
  assign in_use_bit = cpu_clock_source_status ? dev_wdata[RUN_SUB_STOP] :
    (main_source_status ? dev_wdata[RUN_HS_STOP] : dev_wdata[RUN_HIO_STOP]);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sh_css <= 1'b0;
      sh_mcm <= 1'b0;
      pin_seen <= 1'b0;
      stab_seen <= 1'b0;
      x1_pend <= 1'b0;
      xt_pend <= 1'b0;
      xt_age <= 32'h0;
    end else begin
      if (wr_ckc) {sh_css, sh_mcm} <= {dev_wdata[SEL_CPU_SRC], dev_wdata[SEL_MAIN_CTRL]};
      if (dev_wr && dev_addr == DEV_PIN_MODE) pin_seen <= 1'b1;
      if (dev_wr && dev_addr == DEV_STAB_SEL) stab_seen <= 1'b1;
      if (wr_csc && x1_start && !dev_wdata[RUN_HS_STOP]) x1_pend <= 1'b1;
      else if (state == S_CAP_STABILIZATION_COUNTER_STATUS && !rd_wait && (dev_rdata & stab_mask) == stab_mask)
        x1_pend <= 1'b0;
      if (wr_csc && xt_start && !dev_wdata[RUN_SUB_STOP]) begin
        xt_pend <= 1'b1;
        xt_age <= 32'h0;
      end else if (xt_age < SUB_CYC) begin
        xt_age <= xt_age + 32'h1;
      end
      if (xt_age >= SUB_CYC) xt_pend <= 1'b0;
    end
  end

  property p_mcm_fixed;
    @(posedge ref_clk) disable iff (!nrst) wr_ckc && sh_css |-> dev_wdata[SEL_MAIN_CTRL] == sh_mcm;
  endproperty
  a_mcm_fixed: assert property (p_mcm_fixed) else $error("main control moved on sub");
  property p_low_zero;
    @(posedge ref_clk) disable iff (!nrst) wr_ckc |-> dev_wdata[3:0] == 4'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("select low bits not zero");
  property p_hold_switch;
    @(posedge ref_clk) disable iff (!nrst) wr_ckc |-> periph_hold && $past(periph_hold);
  endproperty
  a_hold_switch: assert property (p_hold_switch) else $error("switch without hold");
  property p_pin_first;
    @(posedge ref_clk) disable iff (!nrst) wr_csc |-> pin_seen;
  endproperty
  a_pin_first: assert property (p_pin_first) else $error("run control before pin mode");
  property p_stab_first;
    @(posedge ref_clk) disable iff (!nrst) wr_csc && !dev_wdata[RUN_HS_STOP] |-> stab_seen;
  endproperty
  a_stab_first: assert property (p_stab_first) else $error("start before stab select");
  property p_x1_settled;
    @(posedge ref_clk) disable iff (!nrst) wr_ckc |-> !x1_pend;
  endproperty
  a_x1_settled: assert property (p_x1_settled) else $error("switch before count done");
  property p_xt_settled;
    @(posedge ref_clk) disable iff (!nrst) wr_ckc |-> !xt_pend;
  endproperty
  a_xt_settled: assert property (p_xt_settled) else $error("switch before sub settled");
  property p_no_stop_in_use;
    @(posedge ref_clk) disable iff (!nrst) wr_csc |-> !in_use_bit;
  endproperty
  a_no_stop_in_use: assert property (p_no_stop_in_use) else $error("stopped cpu clock");
  property p_hs_stop_ok;
    @(posedge ref_clk) disable iff (!nrst)
      wr_csc && dev_wdata[RUN_HS_STOP] && !$past(csc_cur[RUN_HS_STOP]) |-> cpu_clock_source_status || !main_source_status;
  endproperty
  a_hs_stop_ok: assert property (p_hs_stop_ok) else $error("high-speed stop in use");
  property p_sub_stop_ok;
    @(posedge ref_clk) disable iff (!nrst)
      wr_csc && dev_wdata[RUN_SUB_STOP] && !$past(csc_cur[RUN_SUB_STOP]) |-> !cpu_clock_source_status;
  endproperty
  a_sub_stop_ok: assert property (p_sub_stop_ok) else $error("sub stop while in use");
  property p_hio_stop_ok;
    @(posedge ref_clk) disable iff (!nrst)
      wr_csc && dev_wdata[RUN_HIO_STOP] && !$past(csc_cur[RUN_HIO_STOP]) |-> cpu_clock_source_status || main_source_status;
  endproperty
  a_hio_stop_ok: assert property (p_hio_stop_ok) else $error("on-chip stop in use");
  property p_cv_sub;
    @(posedge ref_clk) disable iff (!nrst) wr_ckc && dev_wdata[SEL_CPU_SRC];
  endproperty
  c_cv_sub: cover property (p_cv_sub);
  property p_cv_x1;
    @(posedge ref_clk) disable iff (!nrst) state == S_CAP_STABILIZATION_COUNTER_STATUS ##1 state == S_RD_CKC;
  endproperty
  c_cv_x1: cover property (p_cv_x1);
  property p_cv_skip;
    @(posedge ref_clk) disable iff (!nrst) $rose(skipped);
  endproperty
  c_cv_skip: cover property (p_cv_skip);
endmodule
`default_nettype wire

// [sim/scsog_dev_model.sv]
// behavioural model of the clock select and oscillator run registers
// assumes one-cycle write pulses and reads answered the cycle after dev_rd
`timescale 1ns/1ps
`default_nettype none
module scsog_dev_model
  import scsog_pkg::*;
#(
  parameter int SETTLE = 250
) (
  // clock and resets
  input wire logic ref_clk,
  input wire logic por_n,
  input wire logic nrst,
  // byte port
  input wire logic [19:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output logic [7:0] dev_rdata,
  // host behaviour
  input wire logic periph_hold,
  output logic [7:0] bad_count
);
  logic [7:0] clock_run_control, system_clock_select, stabilization_counter_status, stabilization_time_select, pin_mode, rd_val, w;
  logic [1:0] tick;
  logic pin_done;
  int lag, sub_age;
  assign w = dev_wdata;
  always_comb begin
    case (dev_addr)
      DEV_PIN_MODE: rd_val = pin_mode;
      DEV_RUN_CTRL: rd_val = clock_run_control;
      DEV_STAB_CNT: rd_val = stabilization_counter_status;
      DEV_STAB_SEL: rd_val = stabilization_time_select;
      DEV_CLK_SEL: rd_val = system_clock_select;
      default: rd_val = 8'h00;
    endcase
  end
  // a released read line shows the inverse of its last value
  always @(posedge ref_clk) begin
    dev_rdata <= dev_rd ? rd_val : ~dev_rdata;
    tick <= tick + 2'h1;
    if (lag != 0) lag <= lag - 1;
    if (lag == 1) system_clock_select[7] <= system_clock_select[6];
    if (lag == 1) system_clock_select[5] <= system_clock_select[4];
    sub_age <= clock_run_control[6] ? 0 : (sub_age < SETTLE ? sub_age + 1 : sub_age);
    if (!clock_run_control[7] && tick == 2'h3) stabilization_counter_status <= {1'b1, stabilization_counter_status[7:1]};
    if (dev_wr && dev_addr == DEV_PIN_MODE) pin_mode <= w;
    if (dev_wr && dev_addr == DEV_PIN_MODE) pin_done <= 1'b1;
    if (dev_wr && dev_addr == DEV_STAB_SEL) stabilization_time_select <= {5'h00, w[2:0]};
    if (dev_wr && dev_addr == DEV_RUN_CTRL) begin
      bad_count <= bad_count + {7'h00, !pin_done}
        + {7'h00, w[7] && !clock_run_control[7] && !system_clock_select[7] && system_clock_select[5]}
        + {7'h00, w[6] && !clock_run_control[6] && system_clock_select[7]}
        + {7'h00, w[0] && !clock_run_control[0] && !system_clock_select[7] && !system_clock_select[5]};
      clock_run_control <= w & 8'hc1;
      if (w[7]) stabilization_counter_status <= 8'h00;
    end
    if (dev_wr && dev_addr == DEV_CLK_SEL) begin
      bad_count <= bad_count + {7'h00, w[3:0] != 4'h0}
        + {7'h00, system_clock_select[6] && w[4] != system_clock_select[4]}
        + {7'h00, !periph_hold}
        + {7'h00, w[4] && !system_clock_select[4] && !stabilization_counter_status[7]}
        + {7'h00, w[6] && !system_clock_select[6] && sub_age < SETTLE};
      system_clock_select[6] <= w[6];
      system_clock_select[4] <= w[4];
      lag <= 3;
    end
    if (!por_n) clock_run_control[6] <= 1'b1;
    if (!por_n) bad_count <= 8'h00;
    if (!nrst || !por_n) begin
      clock_run_control[7] <= 1'b1;
      clock_run_control[5:0] <= 6'h00;
      system_clock_select <= 8'h00;
      stabilization_counter_status <= 8'h00;
      stabilization_time_select <= 8'h07;
      pin_done <= 1'b0;
      lag <= 0;
      tick <= 2'h0;
      sub_age <= 0;
    end
  end
endmodule
`default_nettype wire

// [sim/system_clock_select_and_osc_gate_bench.sv]
// bench: axi4-lite tasks order clock changes, a device model answers the byte port
// assumes scsog_host and scsog_dev_model compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module system_clock_select_and_osc_gate_bench;
  import scsog_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, por_n = 1'b0, hold_seen = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, dev_wdata, dev_rdata, bad_count;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, dev_wr, dev_rd, periph_hold;
  logic [1:0] bresp, rresp, r;
  logic [19:0] dev_addr;
  int fail_count = 0, total_checks = 0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (periph_hold === 1'b1) hold_seen <= 1'b1;
  scsog_host #(.SUB_SETTLE_US(1), .AXI_AW(8)) dut (.ref_clk(ref_clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .periph_hold(periph_hold));
  scsog_dev_model #(.SETTLE(250)) dev (.ref_clk(ref_clk), .por_n(por_n), .nrst(nrst),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .periph_hold(periph_hold), .bad_count(bad_count));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      r = bresp;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      st = rdata;
      r = rresp;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    rd(a);
    `CHK({r, st}, {er, ed})
  endtask
  // order a change, wait for idle, then compare status and device state
  task automatic apply(input logic [4:0] req, input logic [7:0] csc_e, input logic [7:0] ckc_e,
      input logic [3:0] flags);
    wr(REG_REQUEST, {27'h0, req});
    wr(REG_COMMAND, 32'h1);
    do rd(REG_STATUS); while (st[ST_BUSY] !== 1'b0);
    `CHK(st & 32'h00ffff0f, {8'h00, csc_e, ckc_e, 4'h0, flags})
    `CHK(dev.clock_run_control, csc_e)
    `CHK(dev.system_clock_select, ckc_e)
    `CHK(periph_hold, 1'b0)
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    rdchk(REG_REQUEST, RESP_OKAY, 32'h0c);
    rdchk(REG_STAB_SEL, RESP_OKAY, 32'h07);
    rdchk(8'h14, RESP_SLVERR, 32'h0);
    wr(8'h14, 32'h1);
    `CHK(r, RESP_SLVERR)
    `CHK(dev.clock_run_control, 8'hc0)
    `CHK(dev.system_clock_select, 8'h00)
    wr(REG_PIN_MODE, 32'h40);
    wr(REG_STAB_SEL, 32'h1);
    apply(5'h0a, 8'h40, 8'h30, 4'h2);
    `CHK(hold_seen, 1'b1)
    `CHK(dev.pin_mode, 8'h40)
    `CHK(dev.stabilization_time_select, 8'h01)
    apply(5'h17, 8'h81, 8'hf0, 4'h2);
    apply(5'h0b, 8'h81, 8'hf0, 4'h6);
    apply(5'h0c, 8'hc0, 8'h00, 4'h2);
    apply(5'h04, 8'h80, 8'h00, 4'h2);
    `CHK(dev.bad_count, 8'h00)
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    `CHK(dev.clock_run_control, 8'h80)
    rdchk(REG_REQUEST, RESP_OKAY, 32'h0c);
    end_sim;
  end
endmodule
`default_nettype wire
